// >>> include/prbs_consts.vh
// Constants for the PRBS packet test counter block
`ifndef PRBS_CONSTS_VH
`define PRBS_CONSTS_VH

// Register indices (printed offsets are not multiples of four)
`define PRBS_IDX_BYTE_CNT   8'h71
`define PRBS_IDX_ERR_CNT    8'h72
`define PRBS_IDX_PKT_LEN    8'h7b
`define PRBS_IDX_GAP_LEN    8'h7c
`define PRBS_IDX_CFG        8'h80
`define PRBS_IDX_IRQ_STS    8'h81
`define PRBS_IDX_IRQ_MASK   8'h82
`define PRBS_IDX_PKT_CNT    8'h83

// Field positions
`define PRBS_BIT_LOCK       0
`define PRBS_BIT_LOCK_CLR   1
`define PRBS_BIT_BYTE_OVF   9
`define PRBS_BIT_PKT_OVF    10
`define PRBS_BIT_CFG_EN     0
`define PRBS_BIT_CFG_WRAP   1
`define PRBS_IRQ_ERR        0
`define PRBS_IRQ_BYTE_OVF   1
`define PRBS_IRQ_PKT_OVF    2
`define PRBS_IRQ_PKT_DONE   3

// Reset values
`define PRBS_RST_PKT_LEN    16'h05dc
`define PRBS_RST_GAP_LEN    8'h7d
`define PRBS_GAP_UNIT       4

// AXI responses
`define PRBS_RESP_OKAY      2'b00
`define PRBS_RESP_SLVERR    2'b10

`endif

// >>> src/prbs_lfsr.v
// PRBS-7 byte generator, one byte per enable
`timescale 1ns/1ns
`default_nettype none

module prbs_lfsr #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Control
  input  wire       step,
  output wire [7:0] byte_out
);

  reg [WIDTH-1:0] state_reg;
  reg [WIDTH-1:0] state_next;
  reg [7:0]       byte_next;
  integer         i;

  // Advance eight bits per step so every byte is fresh
  always @* begin
    state_next = state_reg;
    byte_next  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      byte_next[i] = state_next[WIDTH-1] ^ state_next[WIDTH-2];
      state_next   = {state_next[WIDTH-2:0], byte_next[i]};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= {WIDTH{1'b1}};
    end else if (step) begin
      state_reg <= state_next;
    end
  end

  assign byte_out = byte_next;

endmodule

`default_nettype wire

// >>> src/prbs_sat_counter.v
// Counter that saturates or wraps, with overflow flag
`timescale 1ns/1ns
`default_nettype none

module prbs_sat_counter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Control
  input  wire             inc,
  input  wire             clr,
  input  wire             wrap_mode,
  // Status
  output reg  [WIDTH-1:0] count,
  output reg              ovf
);

  wire at_max = &count;

  // Clear wins over increment: clearing is a software request to restart
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {WIDTH{1'b0}};
      ovf   <= 1'b0;
    end else if (clr) begin
      count <= {WIDTH{1'b0}};
      ovf   <= 1'b0;
    end else if (inc) begin
      if (!at_max || wrap_mode) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      if (at_max) begin
        ovf <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> src/prbs_test_top.v
// PRBS packet generator, checker, counters and AXI4-Lite register slave
// Operation
// RULE1 - Keep 8-bit errored byte count
// RULE2 - Write bit 0 freezes counter readings
// RULE3 - Write bit 1 freezes then clears counters
// RULE4 - Mode zero saturates error count at 0xff
// RULE5 - Bit 9 flags byte counter overflow
// RULE6 - Bit 10 flags packet counter overflow
// RULE7 - Flags clear only by lock-and-clear write
// RULE8 - Packet length field, default 1500 bytes
// RULE9 - Gap between packets in four-byte units
// RULE10 - 16-bit received byte count, lockable, saturating
// RULE11 - Counters and flags zero after reset
`timescale 1ns/1ns
`default_nettype none
`include "prbs_consts.vh"

module prbs_test_top #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Test data stream (looped back outside)
  output reg  [7:0]        tx_data,
  output reg               tx_valid,
  input  wire [7:0]        rx_data,
  input  wire              rx_valid,
  // Interrupt
  output reg               irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_SEND = 2'b01;
  localparam ST_GAP  = 2'b10;

  // Software registers
  reg  [15:0] pkt_len_reg;
  reg  [7:0]  gap_len_reg;
  reg         gen_en_reg;
  reg         wrap_mode_reg;
  reg  [3:0]  irq_sts_reg;
  reg  [3:0]  irq_mask_reg;
  // Frozen counter images
  reg  [15:0] byte_snap_reg;
  reg  [7:0]  err_snap_reg;
  reg  [15:0] pkt_snap_reg;
  reg         lock_reg;
  reg         clr_pend_reg;
  // Generator
  reg  [1:0]  state_reg;
  reg  [15:0] byte_idx_reg;
  reg  [9:0]  gap_cnt_reg;
  reg         pkt_done_reg;
  // Checker pipeline
  reg  [7:0]  rx_data_reg;
  reg         rx_valid_reg;
  // AXI holding registers
  reg  [ADDR_W-1:0] aw_addr_reg;
  reg               aw_have_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;
  reg               w_have_reg;

  wire [7:0]  gen_byte;
  wire [7:0]  chk_byte;
  wire [15:0] byte_cnt;
  wire [7:0]  err_cnt;
  wire [15:0] pkt_cnt;
  wire        byte_ovf;
  wire        err_ovf;
  wire        pkt_ovf;
  wire        gen_step;
  wire        rx_err;
  wire        wr_fire;
  wire [7:0]  wr_idx;
  wire [7:0]  rd_idx;
  wire        lock_wr;
  wire        clr_wr;

  // Register index from a byte address
  function [7:0] addr_idx;
    input [ADDR_W-1:0] a;
    begin
      addr_idx = a[9:2];
    end
  endfunction

  function idx_mapped;
    input [7:0] idx;
    begin
      idx_mapped = (idx == `PRBS_IDX_BYTE_CNT) || (idx == `PRBS_IDX_ERR_CNT) ||
                   (idx == `PRBS_IDX_PKT_LEN)  || (idx == `PRBS_IDX_GAP_LEN) ||
                   (idx == `PRBS_IDX_CFG)      || (idx == `PRBS_IDX_IRQ_STS) ||
                   (idx == `PRBS_IDX_IRQ_MASK) || (idx == `PRBS_IDX_PKT_CNT);
    end
  endfunction

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_idx  = addr_idx(aw_addr_reg);
  assign rd_idx  = addr_idx(s_axi_araddr);
  // Any byte-0 write to the error register may carry lock commands
  assign lock_wr = wr_fire && (wr_idx == `PRBS_IDX_ERR_CNT) && w_strb_reg[0] &&
                   w_data_reg[`PRBS_BIT_LOCK];                     // [RULE2]
  assign clr_wr  = wr_fire && (wr_idx == `PRBS_IDX_ERR_CNT) && w_strb_reg[0] &&
                   w_data_reg[`PRBS_BIT_LOCK_CLR];                 // [RULE3]

  // Generator sequencing
  assign gen_step = (state_reg == ST_SEND);

  prbs_lfsr #(.WIDTH(7)) u_gen (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .step     (gen_step),
    .byte_out (gen_byte)
  );

  // Checker reference advances only on received bytes
  prbs_lfsr #(.WIDTH(7)) u_ref (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .step     (rx_valid_reg),
    .byte_out (chk_byte)
  );

  assign rx_err = rx_valid_reg && (rx_data_reg != chk_byte);

  prbs_sat_counter #(.WIDTH(16)) u_byte_cnt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .inc       (rx_valid_reg),
    .clr       (clr_pend_reg),
    .wrap_mode (wrap_mode_reg),
    .count     (byte_cnt),
    .ovf       (byte_ovf)
  ); // [RULE10] [RULE5]

  prbs_sat_counter #(.WIDTH(8)) u_err_cnt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .inc       (rx_err),
    .clr       (clr_pend_reg),
    .wrap_mode (wrap_mode_reg),
    .count     (err_cnt),
    .ovf       (err_ovf)
  ); // [RULE1] [RULE4]

  prbs_sat_counter #(.WIDTH(16)) u_pkt_cnt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .inc       (pkt_done_reg),
    .clr       (clr_pend_reg),
    .wrap_mode (wrap_mode_reg),
    .count     (pkt_cnt),
    .ovf       (pkt_ovf)
  ); // [RULE6] [RULE7]

  // Packet generator: send length bytes, then idle gap of 4-byte units
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_IDLE;
      byte_idx_reg <= 16'h0000;
      gap_cnt_reg  <= 10'h000;
      tx_data      <= 8'h00;
      tx_valid     <= 1'b0;
      pkt_done_reg <= 1'b0;
    end else begin
      tx_valid     <= 1'b0;
      pkt_done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          byte_idx_reg <= 16'h0000;
          if (gen_en_reg && (pkt_len_reg != 16'h0000)) begin
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          tx_data  <= gen_byte;
          tx_valid <= 1'b1;
          if (byte_idx_reg == pkt_len_reg - 16'h0001) begin       // [RULE8]
            pkt_done_reg <= 1'b1;
            byte_idx_reg <= 16'h0000;
            gap_cnt_reg  <= {gap_len_reg, 2'b00};                   // [RULE9]
            state_reg    <= ST_GAP;
          end else begin
            byte_idx_reg <= byte_idx_reg + 16'h0001;
          end
        end
        ST_GAP: begin
          // A zero gap still costs one idle cycle, keeping packets apart
          if (gap_cnt_reg <= 10'h001) begin                        // [RULE9]
            state_reg <= (gen_en_reg && (pkt_len_reg != 16'h0000)) ? ST_SEND : ST_IDLE;
          end else begin
            gap_cnt_reg <= gap_cnt_reg - 10'h001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive stage, same clock as the loopback source
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_reg  <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_data_reg  <= rx_data;
      rx_valid_reg <= rx_valid;
    end
  end

  // Lock freezes the readable images; clear follows one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      byte_snap_reg <= 16'h0000;                                   // [RULE11]
      err_snap_reg  <= 8'h00;
      pkt_snap_reg  <= 16'h0000;
      lock_reg      <= 1'b0;
      clr_pend_reg  <= 1'b0;
    end else begin
      clr_pend_reg <= clr_wr;                                      // [RULE3]
      if (lock_wr || clr_wr) begin
        byte_snap_reg <= byte_cnt;                                 // [RULE2]
        err_snap_reg  <= err_cnt;
        pkt_snap_reg  <= pkt_cnt;
        lock_reg      <= 1'b1;
      end
    end
  end

  // AXI write channel capture, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= {ADDR_W{1'b0}};
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PRBS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_mapped(wr_idx) ? `PRBS_RESP_OKAY : `PRBS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      pkt_len_reg   <= `PRBS_RST_PKT_LEN;                          // [RULE8]
      gap_len_reg   <= `PRBS_RST_GAP_LEN;
      gen_en_reg    <= 1'b0;
      wrap_mode_reg <= 1'b0;
      irq_mask_reg  <= 4'h0;
    end else if (wr_fire) begin
      if (wr_idx == `PRBS_IDX_PKT_LEN) begin
        if (w_strb_reg[0]) pkt_len_reg[7:0]  <= w_data_reg[7:0];
        if (w_strb_reg[1]) pkt_len_reg[15:8] <= w_data_reg[15:8];
      end else if (wr_idx == `PRBS_IDX_GAP_LEN) begin
        if (w_strb_reg[0]) gap_len_reg <= w_data_reg[7:0];
      end else if (wr_idx == `PRBS_IDX_CFG) begin
        if (w_strb_reg[0]) begin
          gen_en_reg    <= w_data_reg[`PRBS_BIT_CFG_EN];
          wrap_mode_reg <= w_data_reg[`PRBS_BIT_CFG_WRAP];         // [RULE4]
        end
      end else if (wr_idx == `PRBS_IDX_IRQ_MASK) begin
        if (w_strb_reg[0]) irq_mask_reg <= w_data_reg[3:0];
      end
    end
  end

  // Sticky interrupt status; a new event wins over a write-one clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_reg <= 4'h0;
      irq         <= 1'b0;
    end else begin
      irq_sts_reg <= (irq_sts_reg &
                      ~((wr_fire && (wr_idx == `PRBS_IDX_IRQ_STS) && w_strb_reg[0]) ?
                        w_data_reg[3:0] : 4'h0)) |
                     {pkt_done_reg, pkt_ovf, byte_ovf, err_ovf};
      irq         <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  // Read channel: one access at a time, answer one cycle after address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PRBS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= idx_mapped(rd_idx) ? `PRBS_RESP_OKAY : `PRBS_RESP_SLVERR;
      // Reads never touch the overflow flags
      if (rd_idx == `PRBS_IDX_BYTE_CNT) begin
        s_axi_rdata <= {16'h0000, lock_reg ? byte_snap_reg : byte_cnt};
      end else if (rd_idx == `PRBS_IDX_ERR_CNT) begin
        s_axi_rdata <= {21'h000000, pkt_ovf, byte_ovf, 1'b0,
                        lock_reg ? err_snap_reg : err_cnt};          // [RULE5] [RULE6]
      end else if (rd_idx == `PRBS_IDX_PKT_LEN) begin
        s_axi_rdata <= {16'h0000, pkt_len_reg};
      end else if (rd_idx == `PRBS_IDX_GAP_LEN) begin
        s_axi_rdata <= {24'h000000, gap_len_reg};
      end else if (rd_idx == `PRBS_IDX_CFG) begin
        s_axi_rdata <= {28'h0000000, state_reg, wrap_mode_reg, gen_en_reg};
      end else if (rd_idx == `PRBS_IDX_IRQ_STS) begin
        s_axi_rdata <= {28'h0000000, irq_sts_reg};
      end else if (rd_idx == `PRBS_IDX_IRQ_MASK) begin
        s_axi_rdata <= {28'h0000000, irq_mask_reg};
      end else if (rd_idx == `PRBS_IDX_PKT_CNT) begin
        s_axi_rdata <= {16'h0000, lock_reg ? pkt_snap_reg : pkt_cnt};
      end else begin
        s_axi_rdata <= 32'h00000000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/prbs_tc_chk.sv
// Bus protocol and register field checker for the PRBS test counter block
`timescale 1ns/1ns
`default_nettype none
`include "prbs_consts.vh"
module prbs_tc_chk #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Write channels
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Stream and interrupt
  input wire logic              tx_valid,
  input wire logic              irq
);
  logic [7:0] rd_idx_reg;
  logic       rd_ok;
  // Index of the pending read, so field checks know which register answers
  always @(posedge aclk) begin
    if (!aresetn) rd_idx_reg <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_idx_reg <= s_axi_araddr[9:2];
  end
  assign rd_ok = s_axi_rvalid && s_axi_rresp == `PRBS_RESP_OKAY;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshake steps
  sequence seq_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence seq_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (seq_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (seq_rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !tx_valid && !irq)
    else $error("outputs active in reset");
  chk_err_fields: assert property (rd_ok && rd_idx_reg == `PRBS_IDX_ERR_CNT |->
    s_axi_rdata[31:11] == 0 && !s_axi_rdata[8]) else $error("error word reserved bits");
  chk_byte_field: assert property (rd_ok && rd_idx_reg == `PRBS_IDX_BYTE_CNT |->
    s_axi_rdata[31:16] == 0) else $error("byte tally too wide");
  chk_gap_field: assert property (rd_ok && rd_idx_reg == `PRBS_IDX_GAP_LEN |->
    s_axi_rdata[31:8] == 0) else $error("gap field too wide");
  chk_len_field: assert property (rd_ok && rd_idx_reg == `PRBS_IDX_PKT_LEN |->
    s_axi_rdata[31:16] == 0) else $error("length field too wide");
  chk_unmapped_err: assert property (s_axi_rvalid && rd_idx_reg == 8'h00 |->
    s_axi_rresp == `PRBS_RESP_SLVERR) else $error("unmapped read not refused");
endmodule
`default_nettype wire

// >>> testbench/prbs_packet_test_counters_test.sv
// Self-checking bench for the PRBS packet test counter block
`timescale 1ns/1ns
`default_nettype none
`include "prbs_consts.vh"
module prbs_packet_test_counters_test;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_v;
  logic [7:0]  tx_data, rx_data = 0, inj;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, rsp;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, rx_valid = 0, awready, wready, bvalid, arready, rvalid;
  logic        tx_valid, irq, flood = 0, seen = 0;
  int          mismatches, tests_run, m_bytes, m_errs, s_bytes, cyc, run, idle, plen, gap;
  int          runs[$], gaps[$];
  always #2 aclk = ~aclk;
  prbs_test_top #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .irq(irq));
  // Loopback with random corruption; the model counts each looped-back byte it hands over, not flood bytes
  always @(posedge aclk) begin
    inj = ($urandom % 4 == 0) ? 8'h01 << ($urandom % 8) : 8'h00;
    rx_valid <= flood | tx_valid;
    rx_data <= flood ? 8'($urandom) : tx_data ^ inj;
    if (tx_valid && !flood) m_bytes++;
    if (tx_valid && !flood && inj != 0) m_errs++;
    if (tx_valid) begin
      if (run == 0 && seen) gaps.push_back(idle);
      run++;
      idle = 0;
    end else begin
      if (run > 0) runs.push_back(run);
      if (run > 0) seen = 1;
      run = 0;
      idle++;
    end
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write and read hold each channel until its own ready is sampled
  task automatic wr(input [7:0] idx, input [31:0] d, input [1:0] er = `PRBS_RESP_OKAY);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1'($urandom);
    // This wait ends on the bvalid and bready handshake; a late bready exercises a held response
    while (!(bready && bvalid)) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) bready <= 1;
    end
    bready <= 0;
    chk("write response", 32'(er), 32'(bresp));
    @(posedge aclk);
  endtask
  task automatic rd(input [7:0] idx, output [31:0] d, output [1:0] r);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1;
    rready <= 1'($urandom);
    while (!(rready && rvalid)) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) rready <= 1;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic rchk(input string what, input [7:0] idx, input [31:0] exp);
    rd(idx, rd_v, rsp);
    chk(what, exp, rd_v);
    chk("read response", 32'(`PRBS_RESP_OKAY), 32'(rsp));
  endtask
  // Run the generator a few packets, then measure frames and gaps seen on the stream
  task automatic traffic;
    wr(`PRBS_IDX_CFG, 32'h1);
    repeat (6 * (plen + 4 * gap)) @(posedge aclk);
    wr(`PRBS_IDX_CFG, 32'h0);
    repeat (plen + 4 * gap + 8) @(posedge aclk);
    for (int i = 0; i + 1 < runs.size(); i++) chk("frame length", plen, runs[i]);
    for (int i = 0; i + 1 < gaps.size(); i++) chk("frame gap", 4 * gap, gaps[i]);
    runs.delete();
    gaps.delete();
    seen = 0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h00cc028b));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rchk("length reset", `PRBS_IDX_PKT_LEN, 32'h05dc);
    rchk("gap reset", `PRBS_IDX_GAP_LEN, 32'h007d);
    rchk("errors reset", `PRBS_IDX_ERR_CNT, 32'h0);
    rchk("bytes reset", `PRBS_IDX_BYTE_CNT, 32'h0);
    rd(8'h00, rd_v, rsp);
    chk("unmapped read", 32'(`PRBS_RESP_SLVERR), 32'(rsp));
    wr(8'h00, 32'h0, `PRBS_RESP_SLVERR);
    $display("test registers done");
    plen = 4 + $urandom % 9;
    gap = 1 + $urandom % 4;
    wr(`PRBS_IDX_PKT_LEN, plen);
    wr(`PRBS_IDX_GAP_LEN, gap);
    rchk("length", `PRBS_IDX_PKT_LEN, plen);
    traffic();
    chk("irq masked", 0, 32'(irq));
    wr(`PRBS_IDX_IRQ_MASK, 32'h8);
    repeat (2) @(posedge aclk);
    chk("irq raised", 1, 32'(irq));
    wr(`PRBS_IDX_IRQ_STS, 32'h8);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 0, 32'(irq));
    wr(`PRBS_IDX_ERR_CNT, 32'h1);
    s_bytes = m_bytes;
    rchk("bytes", `PRBS_IDX_BYTE_CNT, m_bytes);
    rchk("errors", `PRBS_IDX_ERR_CNT, m_errs);
    $display("test traffic done");
    traffic();
    rchk("bytes frozen", `PRBS_IDX_BYTE_CNT, s_bytes);
    wr(`PRBS_IDX_ERR_CNT, 32'h1);
    rchk("bytes relocked", `PRBS_IDX_BYTE_CNT, m_bytes);
    rchk("errors relocked", `PRBS_IDX_ERR_CNT, m_errs);
    wr(`PRBS_IDX_ERR_CNT, 32'h2);
    wr(`PRBS_IDX_ERR_CNT, 32'h1);
    rchk("bytes cleared", `PRBS_IDX_BYTE_CNT, 32'h0);
    rchk("errors cleared", `PRBS_IDX_ERR_CNT, 32'h0);
    $display("test lock done");
    wr(`PRBS_IDX_IRQ_MASK, 32'h2);
    flood <= 1;
    repeat (65540) @(posedge aclk);
    flood <= 0;
    repeat (4) @(posedge aclk);
    wr(`PRBS_IDX_ERR_CNT, 32'h1);
    rchk("bytes saturated", `PRBS_IDX_BYTE_CNT, 32'hffff);
    rchk("errors saturated", `PRBS_IDX_ERR_CNT, 32'h02ff);
    chk("irq overflow", 1, 32'(irq));
    rchk("flags kept", `PRBS_IDX_ERR_CNT, 32'h02ff);
    wr(`PRBS_IDX_ERR_CNT, 32'h2);
    wr(`PRBS_IDX_ERR_CNT, 32'h1);
    rchk("flags cleared", `PRBS_IDX_ERR_CNT, 32'h0);
    wr(`PRBS_IDX_IRQ_STS, 32'hf);
    repeat (2) @(posedge aclk);
    chk("irq dropped", 0, 32'(irq));
    wr(`PRBS_IDX_CFG, 32'h2);
    rchk("wrap mode", `PRBS_IDX_CFG, 32'h2);
    $display("test saturation done");
    give_verdict();
  end
endmodule
bind prbs_test_top prbs_tc_chk #(.ADDR_W(ADDR_W)) i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .tx_valid(tx_valid), .irq(irq));
`default_nettype wire
